//--- pkg/t8sp_pkg.sv
// Purpose: Shared constants and types for the eight-bit timer with shared prescaler.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Register offsets are byte addresses.
`default_nettype none
package t8sp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_PRESC = 8'h10;
  // Field positions and widths
  localparam int SEL_W = 3;
  localparam int WRAP_IE_BIT = 0;
  localparam int WRAP_FLAG_BIT = 0;
  localparam int RESTART_BIT = 0;
  localparam int PRESC_W = 10;
  // Reset values and counter maximum
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [PRESC_W-1:0] PRESC_RST = 10'h000;
  // Tick source select codes
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_SYS = 3'h1;
  localparam logic [2:0] SEL_DIV8 = 3'h2;
  localparam logic [2:0] SEL_DIV64 = 3'h3;
  localparam logic [2:0] SEL_DIV256 = 3'h4;
  localparam logic [2:0] SEL_DIV1024 = 3'h5;
  localparam logic [2:0] SEL_EXT_FALL = 3'h6;
  localparam logic [2:0] SEL_EXT_RISE = 3'h7;
  // Prescaler tap count and terminal masks (divide by 8, 64, 256, 1024)
  localparam int NTAPS = 4;
  localparam logic [PRESC_W-1:0] TAP_MASK [NTAPS] = '{10'h007, 10'h03f, 10'h0ff, 10'h3ff};
  // APB request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } t8sp_apb_req_t;
endpackage : t8sp_pkg
`default_nettype wire

//--- rtl/t8sp_timer.sv
// Purpose: Eight-bit up counter with selectable tick source and shared free prescaler.
// Assumes: All inputs synchronous to mclk except ext_count_pin, which is synchronised.
// Notes: Prescaler taps are also driven out registered for the second timer.
`default_nettype none
// How it works
// - Three-bit source select in control bits 2..0; zero stops the counter.
// - Select 1 counts every system clock cycle.
// - Selects 2..5 use prescaler taps dividing by 8, 64, 256, 1024.
// - Select 6 counts falling pin edges, select 7 rising pin edges.
// - Pin edges count regardless of the pin's own direction setting.
// - Count register is readable and writable at any time.
// - Mask bit 0 plus global enable plus flag raise the wrap interrupt.
// - Wrap flag, flag bit 0, is set when the counter overflows.
// - Flag clears on vector acknowledge or written one; zero keeps it.
// - One prescaler serves both timers; each has its own select.
// - Prescaler runs freely, so first prescaled count lands 1..N cycles later.
// - Prescaler restart restarts the period for every connected timer.
// - Counting pin is sampled once per system clock on the rising edge.
// - Pin edge to counter update takes 2 to 3 cycles.
// - Pin ticks never pass through the prescaler.
// - Fully synchronous; selected tick is a one-cycle enable.
// - Counts up only, wraps 0xff to 0x00, flag set in that cycle.
// - Software count write beats a simultaneous count.
// - Prescaler restart bit self-clears, zero writes ignored, reads zero.
module t8sp_timer (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire t8sp_pkg::t8sp_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin,
  input wire logic global_irq_enable,
  input wire logic wrap_vector_ack,
  output logic wrap_irq,
  output logic [t8sp_pkg::NTAPS-1:0] presc_taps
);
  logic [2:0] sel_q;
  logic [7:0] count_q;
  logic [7:0] mask_q;
  logic wrap_flag_q;
  logic [t8sp_pkg::PRESC_W-1:0] presc_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_prev_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic wrap_irq_q;
  logic [t8sp_pkg::NTAPS-1:0] taps_q;
  logic [t8sp_pkg::NTAPS-1:0] tap_hit;
  logic setup;
  logic wr_done;
  logic mapped;
  logic timer_tick;
  logic rise;
  logic fall;
  logic wr_ctrl;
  logic wr_count;
  logic wr_mask;
  logic wr_flags;
  logic wr_presc;
  logic restart;
  logic wrap_set;
  logic wrap_clr;
  logic [31:0] rd_mux;

  // Bus phase decode
  // A write lands only at the edge that completes the access phase
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_done = apb_req.psel && apb_req.penable && pready_q && apb_req.pwrite && !pslverr_q;
  assign wr_ctrl = wr_done && (apb_req.paddr == t8sp_pkg::OFF_CTRL);
  assign wr_count = wr_done && (apb_req.paddr == t8sp_pkg::OFF_COUNT);
  assign wr_mask = wr_done && (apb_req.paddr == t8sp_pkg::OFF_MASK);
  assign wr_flags = wr_done && (apb_req.paddr == t8sp_pkg::OFF_FLAGS);
  assign wr_presc = wr_done && (apb_req.paddr == t8sp_pkg::OFF_PRESC);

  // Address map check and read data
  // Unmapped offsets read zero and raise an error with the answer
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (apb_req.paddr)
      t8sp_pkg::OFF_CTRL: rd_mux = {29'h0000_0000, sel_q};
      t8sp_pkg::OFF_COUNT: rd_mux = {24'h00_0000, count_q};
      t8sp_pkg::OFF_MASK: rd_mux = {24'h00_0000, mask_q};
      t8sp_pkg::OFF_FLAGS: rd_mux = {31'h0000_0000, wrap_flag_q};
      t8sp_pkg::OFF_PRESC: rd_mux = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  // Answer one cycle after setup: ready, error and read data registered
  // Read data is captured at setup so it stands through the access cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup && !apb_req.pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Control register: only the select field is stored
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sel_q <= t8sp_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      sel_q <= apb_req.pwdata[t8sp_pkg::SEL_W-1:0];
    end
  end

  // Mask register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mask_q <= t8sp_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_q <= apb_req.pwdata[7:0];
    end
  end

  // Free-running shared prescaler; restart clears it for all users
  // It ignores the select field, so a prescaled start is not phase aligned
  assign restart = wr_presc && apb_req.pwdata[t8sp_pkg::RESTART_BIT];
  always_ff @(posedge mclk) begin
    if (sys_rst || restart) begin
      presc_q <= t8sp_pkg::PRESC_RST;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // One tap pulse per divider period
  // A tap fires when the low prescaler bits are all ones
  genvar gi;
  generate
    for (gi = 0; gi < t8sp_pkg::NTAPS; gi++) begin : g_tap
      assign tap_hit[gi] = (presc_q & t8sp_pkg::TAP_MASK[gi]) == t8sp_pkg::TAP_MASK[gi];
    end
  endgenerate

  // Taps handed to the second timer
  // Registered so the other timer sees clean single-cycle pulses
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      taps_q <= '0;
    end else begin
      taps_q <= tap_hit;
    end
  end

  // Pin synchroniser and edge history
  // Two flops tame metastability; the third keeps the last level for edges
  // History resets low like the idle pin, so reset gives no false edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= ext_count_pin;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end
  assign rise = pin_s2_q && !pin_prev_q;
  assign fall = !pin_s2_q && pin_prev_q;

  // Tick source mux: one-cycle enable, pin edges bypass the prescaler
  // Only this enable reaches the counter, so there is no second clock
  always_comb begin
    case (sel_q)
      t8sp_pkg::SEL_OFF: timer_tick = 1'b0;
      t8sp_pkg::SEL_SYS: timer_tick = 1'b1;
      t8sp_pkg::SEL_DIV8: timer_tick = tap_hit[0];
      t8sp_pkg::SEL_DIV64: timer_tick = tap_hit[1];
      t8sp_pkg::SEL_DIV256: timer_tick = tap_hit[2];
      t8sp_pkg::SEL_DIV1024: timer_tick = tap_hit[3];
      t8sp_pkg::SEL_EXT_FALL: timer_tick = fall;
      t8sp_pkg::SEL_EXT_RISE: timer_tick = rise;
      default: timer_tick = 1'b0;
    endcase
  end

  // Counter: write wins, otherwise count up with wrap
  // A software write in the same cycle as a tick discards that tick
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_q <= t8sp_pkg::COUNT_RST;
    end else if (wr_count) begin
      count_q <= apb_req.pwdata[7:0];
    end else if (timer_tick) begin
      count_q <= count_q + 8'h01;
    end
  end

  // Wrap flag: set beats clear
  // An overflow in the clearing cycle keeps the flag, so no wrap is lost
  assign wrap_set = timer_tick && !wr_count && (count_q == t8sp_pkg::COUNT_MAX);
  assign wrap_clr = wrap_vector_ack || (wr_flags && apb_req.pwdata[t8sp_pkg::WRAP_FLAG_BIT]);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrap_flag_q <= 1'b0;
    end else if (wrap_set) begin
      wrap_flag_q <= 1'b1;
    end else if (wrap_clr) begin
      wrap_flag_q <= 1'b0;
    end
  end

  // Interrupt request
  // Level request; the core drops it by acknowledging the vector
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrap_irq_q <= 1'b0;
    end else begin
      wrap_irq_q <= wrap_flag_q && mask_q[t8sp_pkg::WRAP_IE_BIT] && global_irq_enable;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wrap_irq = wrap_irq_q;
  assign presc_taps = taps_q;

  // Checks below sample on the rising clock and pause during reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  stop_holds_a: assert property (
    (sel_q == t8sp_pkg::SEL_OFF) && !wr_count |=> $stable(count_q))
    else $error("Counter moved while stopped");

  sys_counts_a: assert property (
    (sel_q == t8sp_pkg::SEL_SYS) && !wr_count |=> count_q == $past(count_q) + 8'h01)
    else $error("System tick did not advance counter");

  div8_period_a: assert property (
    (sel_q == t8sp_pkg::SEL_DIV8) && timer_tick && !restart |=> !timer_tick [*7])
    else $error("Divide by 8 tick too frequent");

  rise_edge_a: assert property (
    (sel_q == t8sp_pkg::SEL_EXT_RISE) && $rose(pin_s2_q) |-> timer_tick)
    else $error("Rising pin edge gave no tick");

  pin_delay_a: assert property (
    $rose(pin_s1_q) ##1 (sel_q == t8sp_pkg::SEL_EXT_RISE) && !wr_count
    |=> count_q != $past(count_q))
    else $error("Pin edge not counted after two cycles");

  write_wins_a: assert property (
    wr_count |=> count_q == $past(apb_req.pwdata[7:0]))
    else $error("Count write lost");

  wrap_flag_a: assert property (
    timer_tick && !wr_count && count_q == t8sp_pkg::COUNT_MAX |=> wrap_flag_q && count_q == 8'h00)
    else $error("Wrap did not set flag");

  flag_clear_a: assert property (
    wrap_clr && !wrap_set |=> !wrap_flag_q)
    else $error("Flag not cleared");

  irq_gate_a: assert property (
    wrap_irq |-> $past(wrap_flag_q && mask_q[t8sp_pkg::WRAP_IE_BIT] && global_irq_enable))
    else $error("Interrupt without all enables");

  restart_a: assert property (
    restart |=> presc_q == t8sp_pkg::PRESC_RST ##1 presc_q == 10'h001)
    else $error("Prescaler restart failed");

  ctrl_upper_a: assert property (
    pready_q && !pslverr_q && !$past(apb_req.pwrite) && $past(apb_req.paddr) == t8sp_pkg::OFF_CTRL
    |-> prdata_q[31:3] == '0)
    else $error("Control upper bits not zero");

  // Tick source selection: idle, every cycle and prescaled spacing
  off_no_tick_a: assert property (
    sel_q == t8sp_pkg::SEL_OFF |-> !timer_tick)
    else $error("Tick while source is off");

  sys_every_tick_a: assert property (
    sel_q == t8sp_pkg::SEL_SYS |-> timer_tick)
    else $error("System source missed a tick");

  div64_gap_a: assert property (
    (sel_q == t8sp_pkg::SEL_DIV64) && timer_tick |=> !timer_tick [*8])
    else $error("Divide by 64 tick too frequent");

  div256_gap_a: assert property (
    (sel_q == t8sp_pkg::SEL_DIV256) && timer_tick |=> !timer_tick [*8])
    else $error("Divide by 256 tick too frequent");

  div1024_gap_a: assert property (
    (sel_q == t8sp_pkg::SEL_DIV1024) && timer_tick |=> !timer_tick [*8])
    else $error("Divide by 1024 tick too frequent");

  // Shared prescaler: free running, restart seen by every tap
  tap8_gap_a: assert property (
    taps_q[0] |=> !taps_q[0] [*7])
    else $error("Shared divide by 8 tap too frequent");

  presc_free_a: assert property (
    !restart |=> presc_q == $past(presc_q) + 10'h001)
    else $error("Prescaler did not run freely");

  restart_taps_a: assert property (
    restart |=> ##1 taps_q == '0)
    else $error("Restart did not clear shared taps");

  // Counting pin: delay, edge choice and single-cycle ticks
  fall_delay_a: assert property (
    $fell(pin_s1_q) ##1 ((sel_q == t8sp_pkg::SEL_EXT_FALL) && !wr_count)
    |=> count_q != $past(count_q))
    else $error("Falling pin edge not counted after two cycles");

  rise_quiet_a: assert property (
    (sel_q == t8sp_pkg::SEL_EXT_RISE) && !rise |-> !timer_tick)
    else $error("Tick without rising pin edge");

  fall_quiet_a: assert property (
    (sel_q == t8sp_pkg::SEL_EXT_FALL) && !fall |-> !timer_tick)
    else $error("Tick without falling pin edge");

  ext_tick_pulse_a: assert property (
    ((sel_q == t8sp_pkg::SEL_EXT_RISE) || (sel_q == t8sp_pkg::SEL_EXT_FALL))
    && timer_tick && !wr_ctrl |=> !timer_tick)
    else $error("Pin tick longer than one cycle");

  // Flag and interrupt
  irq_raise_a: assert property (
    wrap_flag_q && mask_q[t8sp_pkg::WRAP_IE_BIT] && global_irq_enable |=> wrap_irq)
    else $error("Enabled wrap gave no interrupt");

  flag_hold_a: assert property (
    wrap_flag_q && !wrap_clr |=> wrap_flag_q)
    else $error("Flag lost without a clear");

  flag_idle_a: assert property (
    !wrap_flag_q && !wrap_set |=> !wrap_flag_q)
    else $error("Flag set without a wrap");

  // Register bus answer and register contents
  ready_pulse_a: assert property (
    pready_q |=> !pready_q)
    else $error("Ready longer than one cycle");

  ready_follow_a: assert property (
    setup |=> pready_q)
    else $error("No ready after setup");

  err_ready_a: assert property (
    pslverr_q |-> pready_q)
    else $error("Error without ready");

  presc_read_a: assert property (
    pready_q && !$past(apb_req.pwrite) && $past(apb_req.paddr) == t8sp_pkg::OFF_PRESC
    |-> prdata_q == 32'h0000_0000)
    else $error("Restart register read not zero");

  count_read_a: assert property (
    pready_q && !$past(apb_req.pwrite) && $past(apb_req.paddr) == t8sp_pkg::OFF_COUNT
    |-> prdata_q[7:0] == $past(count_q))
    else $error("Count read does not match counter");

  mask_hold_a: assert property (
    !wr_mask |=> $stable(mask_q))
    else $error("Mask changed without a write");

  sel_hold_a: assert property (
    !wr_ctrl |=> $stable(sel_q))
    else $error("Select changed without a write");
endmodule : t8sp_timer
`default_nettype wire

//--- tb/t8sp_pin_src.sv
// Purpose: Event source that drives the external counting pin in bursts.
// Assumes: Half period is given in system cycles and is never below two.
// Notes: Pin rests low and quiet between bursts; busy covers the whole burst.
`default_nettype none
module t8sp_pin_src (
  input wire logic mclk,
  input wire logic start,
  input wire logic [7:0] n_pulses,
  input wire logic [3:0] half_cyc,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int h;
  // Burst generator: n full pulses, then a quiet spell before busy drops
  initial begin
    pin <= 1'b0;
    busy <= 1'b0;
    forever begin
      @(posedge mclk);
      if (start) begin
        busy <= 1'b1;
        h = (half_cyc < 4'h2) ? 2 : int'(half_cyc); // Half period above one cycle
        repeat (2 * int'(n_pulses)) begin
          repeat (h) @(posedge mclk);
          pin <= ~pin;
        end
        repeat (2) @(posedge mclk); // Pin stays stable while source is switched
        busy <= 1'b0;
      end
    end
  end
endmodule : t8sp_pin_src
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the eight-bit timer over APB.
// Assumes: Zero-wait APB slave; pin source model on the counting pin.
// Notes: Prescaled counts are made exact by restarting the prescaler first.
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) fail(g, e); end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CT = t8sp_pkg::OFF_CTRL;
  localparam logic [7:0] A_CN = t8sp_pkg::OFF_COUNT;
  localparam logic [7:0] A_MK = t8sp_pkg::OFF_MASK;
  localparam logic [7:0] A_FL = t8sp_pkg::OFF_FLAGS;
  localparam logic [7:0] A_PR = t8sp_pkg::OFF_PRESC;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  t8sp_pkg::t8sp_apb_req_t apb_req = '0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, re, ext_count_pin, wrap_irq, ps_busy;
  logic gie = 1'b1;
  logic ack = 1'b0;
  logic ps_start = 1'b0;
  logic [7:0] ps_n = 8'h00;
  logic [3:0] ps_h = 4'h2;
  logic [3:0] presc_taps;
  int num_errors = 0;
  int total_checks = 0;
  int tc [4] = '{0, 0, 0, 0};

  t8sp_timer t8sp_timer_i (.mclk(mclk), .sys_rst(sys_rst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
    .global_irq_enable(gie), .wrap_vector_ack(ack), .wrap_irq(wrap_irq),
    .presc_taps(presc_taps));
  t8sp_pin_src t8sp_pin_src_i (.mclk(mclk), .start(ps_start), .n_pulses(ps_n),
    .half_cyc(ps_h), .pin(ext_count_pin), .busy(ps_busy));

  // 200 MHz system clock
  always #2.5 mclk = ~mclk;

  task fail(input logic [31:0] g, input logic [31:0] e);
    num_errors++;
    $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e);
  endtask : fail

  // One APB transfer; psel stays up unless this is the last of a run
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d, input logic last);
    int n;
    n = 0;
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail(32'h0, 32'h1);
    rv = prdata;
    re = pslverr;
    apb_req.penable <= 1'b0;
    if (last) begin
      apb_req.psel <= 1'b0;
      @(posedge mclk);
    end
  endtask : xf

  task wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d, 1'b1);
  endtask : wr

  task rd(input logic [7:0] a);
    xf(1'b0, a, 32'h0, 1'b1);
  endtask : rd

  // Count stopped at fe, two system ticks, stop again
  task wrap_once;
    xf(1'b1, A_CN, 32'hfe, 1'b0);
    xf(1'b1, A_CT, 32'(t8sp_pkg::SEL_SYS), 1'b0);
    wr(A_CT, 32'h0);
  endtask : wrap_once

  task pin_burst(input logic [7:0] n, input logic [3:0] h);
    int k;
    k = 0;
    ps_n <= n;
    ps_h <= h;
    ps_start <= 1'b1;
    @(posedge mclk);
    ps_start <= 1'b0;
    @(posedge mclk);
    while (ps_busy === 1'b1 && k < 500) begin
      @(posedge mclk);
      k++;
    end
    repeat (4) @(posedge mclk);
  endtask : pin_burst

  task give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // Watchdog against a hung handshake
  initial begin
    #100us;
    num_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int a = 0; a <= 16; a += 4) begin
      rd(a[7:0]);
      `CHK(rv, 32'h0)
    end
    wr(A_CT, 32'hffffffff);
    rd(A_CT);
    `CHK(rv, 32'h7)
    rd(8'h14);
    `CHK({re, rv}, 33'h100000000)
    wr(A_MK, 32'ha5);
    rd(A_MK);
    `CHK(rv, 32'ha5)
    wr(A_PR, 32'h1);
    rd(A_PR);
    `CHK(rv, 32'h0)
    wr(A_CT, 32'h0);
    wr(A_MK, 32'h0);
    wr(A_CN, 32'h5a);
    repeat (20) @(posedge mclk);
    rd(A_CN);
    `CHK(rv, 32'h5a)
    xf(1'b1, A_CT, 32'(t8sp_pkg::SEL_SYS), 1'b0);
    xf(1'b1, A_CN, 32'h10, 1'b0);
    wr(A_CT, 32'h0);
    rd(A_CN);
    `CHK(rv, 32'h12)
    wrap_once();
    rd(A_CN);
    `CHK(rv, 32'h0)
    rd(A_FL);
    `CHK(rv, 32'h1)
    `CHK(wrap_irq, 1'b0)
    wr(A_MK, 32'h1);
    repeat (2) @(posedge mclk);
    `CHK(wrap_irq, 1'b1)
    gie <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(wrap_irq, 1'b0)
    gie <= 1'b1;
    wr(A_FL, 32'h0);
    rd(A_FL);
    `CHK(rv, 32'h1)
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(wrap_irq, 1'b0)
    rd(A_FL);
    `CHK(rv, 32'h0)
    wrap_once();
    wr(A_FL, 32'h1);
    rd(A_FL);
    `CHK(rv, 32'h0)
    wr(A_MK, 32'h0);
    // Restart, then run exactly two prescaled periods on each tap
    for (int i = 0; i < 4; i++) begin
      wr(A_CN, 32'h0);
      xf(1'b1, A_PR, 32'h1, 1'b0);
      wr(A_CT, 32'(t8sp_pkg::SEL_DIV8 + 3'(i)));
      repeat (2 * (int'(t8sp_pkg::TAP_MASK[i]) + 1) - 5) @(posedge mclk);
      wr(A_CT, 32'h0);
      rd(A_CN);
      `CHK(rv, 32'h2)
    end
    repeat (1024) begin
      @(posedge mclk);
      for (int k = 0; k < 4; k++) tc[k] += int'(presc_taps[k] === 1'b1);
    end
    for (int k = 0; k < 4; k++) begin
      `CHK(tc[k], 1024 / (int'(t8sp_pkg::TAP_MASK[k]) + 1))
    end
    wr(A_CN, 32'h0);
    wr(A_CT, 32'(t8sp_pkg::SEL_EXT_RISE));
    pin_burst(8'h05, 4'h2);
    rd(A_CN);
    `CHK(rv, 32'h5)
    wr(A_CT, 32'(t8sp_pkg::SEL_EXT_FALL));
    pin_burst(8'h05, 4'h3);
    wr(A_CT, 32'h0);
    rd(A_CN);
    `CHK(rv, 32'ha)
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
